// file: src/sipo_latch_pkg.sv
// Package of constants for the twelve-stage serial-in, parallel-out latch
// Operation
// RQ1: Twelve stages, each with latch and output.
// RQ2: Shift one stage on serial clock rise.
// RQ3: First stage captures serial_in level.
// RQ4: Parallel outputs show inverted latched stages.
// RQ5: Hold low freezes latches and outputs.
// RQ6: Hold high makes latches follow register.
// RQ7: cascade_out always carries true stage twelve.
// RQ8: Gate high forces all outputs high.
// RQ9: Gate changes never disturb shifting.
// RQ10: Host sends twelve bits, then opens hold.
`default_nettype none
package sipo_latch_pkg;

  // Number of shift stages and parallel outputs
  localparam int STAGE_COUNT = 12;

  // Number of pin inputs passed through the synchroniser
  localparam int SYNC_WIDTH = 4;

  // Bit positions of the pins inside the synchronised vector
  localparam int SYNC_SCLK = 0;
  localparam int SYNC_SIN = 1;
  localparam int SYNC_HOLD = 2;
  localparam int SYNC_GATE = 3;

  // Reset levels of the filtered pins: clock low, data low,
  // latches holding, output gate closed
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 4'h8;

  // Reset contents of the shift stages and the output latches
  localparam logic [STAGE_COUNT-1:0] SHIFT_RESET = 12'h000;
  localparam logic [STAGE_COUNT-1:0] LATCH_RESET = 12'h000;

  // Parallel outputs reset high, the same as a closed gate
  localparam logic [STAGE_COUNT-1:0] OUT_RESET = 12'hFFF;

  // Level that a closed gate forces onto every parallel output
  localparam logic [STAGE_COUNT-1:0] OUT_FORCED = 12'hFFF;

  // Reset level of the cascade output
  localparam logic CASCADE_RESET = 1'b0;

endpackage
`default_nettype wire

// file: src/pin_sync_if.sv
// Interface carrying the filtered pin levels from the synchroniser
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if;

  // Filtered pin levels, one bit per pin
  logic [sipo_latch_pkg::SYNC_WIDTH-1:0] level;

  // Synchroniser drives the levels
  modport source (output level);

  // Core logic reads them
  modport sink (input level);

endinterface
`default_nettype wire

// file: src/pin_sync.sv
// Three-flop synchroniser with agreement filter for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [sipo_latch_pkg::SYNC_WIDTH-1:0] pins,
  pin_sync_if.source sync
);

  // Metastability catcher, read only by the second stage
  logic [sipo_latch_pkg::SYNC_WIDTH-1:0] meta_q;
  // Second and third stages, compared to reject a one-cycle glitch
  logic [sipo_latch_pkg::SYNC_WIDTH-1:0] stage2_q;
  logic [sipo_latch_pkg::SYNC_WIDTH-1:0] stage3_q;
  // Accepted level per pin
  logic [sipo_latch_pkg::SYNC_WIDTH-1:0] level_q;

  // Synchroniser chain
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_q <= sipo_latch_pkg::SYNC_RESET;
      stage2_q <= sipo_latch_pkg::SYNC_RESET;
      stage3_q <= sipo_latch_pkg::SYNC_RESET;
    end
    else
    begin
      meta_q <= pins;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // A pin changes only once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      level_q <= sipo_latch_pkg::SYNC_RESET;
    else
    begin
      for (int i = 0; i < sipo_latch_pkg::SYNC_WIDTH; i++)
      begin
        if (stage2_q[i] == stage3_q[i])
          level_q[i] <= stage3_q[i];
      end
    end
  end

  assign sync.level = level_q;

endmodule
`default_nettype wire

// file: src/sipo_latch12.sv
// Twelve-stage serial-in, parallel-out shift register with output latch
`timescale 1ns/10ps
`default_nettype none
module sipo_latch12 (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic output_hold_n,
  input wire logic drive_gate_n,
  output logic [sipo_latch_pkg::STAGE_COUNT-1:0] parallel_out_n,
  output logic cascade_out
);

  // Filtered pin levels from the synchroniser
  pin_sync_if sync_bus ();

  // Pins gathered in the order that the synchroniser expects
  logic [sipo_latch_pkg::SYNC_WIDTH-1:0] pins;

  // Shift stages, bit 0 is the first stage
  logic [sipo_latch_pkg::STAGE_COUNT-1:0] shift_q;
  logic [sipo_latch_pkg::STAGE_COUNT-1:0] shift_d;
  // Output latches, one per stage
  logic [sipo_latch_pkg::STAGE_COUNT-1:0] latch_q;
  logic [sipo_latch_pkg::STAGE_COUNT-1:0] latch_d;
  // Registered parallel outputs, active low
  logic [sipo_latch_pkg::STAGE_COUNT-1:0] parallel_out_n_q;
  // Registered cascade output
  logic cascade_out_q;
  // Last filtered serial clock level, for edge detection
  logic sclk_prev_q;

  // Filtered levels under readable names
  logic sclk_level;
  logic sin_level;
  logic hold_open;
  logic gate_closed;
  // One-cycle pulse on a rising serial clock
  logic shift_edge;

  // Pack the pins; all four come from outside the clock domain
  always_comb
  begin
    pins = '0;
    pins[sipo_latch_pkg::SYNC_SCLK] = serial_clk;
    pins[sipo_latch_pkg::SYNC_SIN] = serial_in;
    pins[sipo_latch_pkg::SYNC_HOLD] = output_hold_n;
    pins[sipo_latch_pkg::SYNC_GATE] = drive_gate_n;
  end

  // Synchroniser for every pin
  pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pins(pins),
    .sync(sync_bus.source)
  );

  // Unpack the filtered levels
  assign sclk_level = sync_bus.level[sipo_latch_pkg::SYNC_SCLK];
  assign sin_level = sync_bus.level[sipo_latch_pkg::SYNC_SIN];
  assign hold_open = sync_bus.level[sipo_latch_pkg::SYNC_HOLD];
  assign gate_closed = sync_bus.level[sipo_latch_pkg::SYNC_GATE];

  // Remember the serial clock level for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_level;
  end

  // Only a low-to-high change shifts; a falling edge does nothing [RQ2]
  assign shift_edge = sclk_level && !sclk_prev_q;

  // Next register contents; the gate plays no part here [RQ9]
  always_comb
  begin
    shift_d = shift_q;
    if (shift_edge)
    begin
      // Each stage takes its predecessor [RQ2]
      shift_d[sipo_latch_pkg::STAGE_COUNT-1:1] = shift_q[sipo_latch_pkg::STAGE_COUNT-2:0];
      // First stage takes the serial input level as is [RQ3]
      shift_d[0] = sin_level;
    end
  end

  // Twelve shift stages [RQ1]
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      shift_q <= sipo_latch_pkg::SHIFT_RESET;
    else
      shift_q <= shift_d;
  end

  // Latches pass the new contents when open, else keep their value
  always_comb
  begin
    if (hold_open)
      latch_d = shift_d; // Transparent, no extra cycle of lag [RQ6]
    else
      latch_d = latch_q; // Frozen while hold is low [RQ5]
  end

  // Output latch per stage [RQ1]
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      latch_q <= sipo_latch_pkg::LATCH_RESET;
    else
      latch_q <= latch_d;
  end

  // Parallel drive: gate forces high, otherwise inverted latches
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      parallel_out_n_q <= sipo_latch_pkg::OUT_RESET;
    else if (gate_closed)
      parallel_out_n_q <= sipo_latch_pkg::OUT_FORCED; // Gate closed [RQ8]
    else
      parallel_out_n_q <= ~latch_d; // Inverted latch content [RQ4]
  end

  // Cascade bypasses latch and gate so chained parts see raw data
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cascade_out_q <= sipo_latch_pkg::CASCADE_RESET;
    else
      cascade_out_q <= shift_d[sipo_latch_pkg::STAGE_COUNT-1]; // [RQ7]
  end

  // Outputs come straight from flip-flops
  assign parallel_out_n = parallel_out_n_q;
  assign cascade_out = cascade_out_q;

  // Whole register moves up one stage on each rise
  AST_SHIFT_MOVES: assert property ( // [RQ2]
    @(posedge clk_sys) disable iff (srst)
    shift_edge |=> shift_q[11:1] == $past(shift_q[10:0])
  ) else $error("register did not move one stage on a rise");

  // Without a rise nothing moves
  AST_SHIFT_STILL: assert property ( // [RQ2]
    @(posedge clk_sys) disable iff (srst)
    !shift_edge |=> shift_q == $past(shift_q)
  ) else $error("register changed without a serial clock rise");

  // First stage takes the serial input level
  AST_FIRST_STAGE: assert property ( // [RQ3]
    @(posedge clk_sys) disable iff (srst)
    shift_edge |=> shift_q[0] == $past(sin_level)
  ) else $error("first stage did not take serial input");

  // Open gate shows the inverted latches on all twelve outputs
  AST_OUT_INVERTED: assert property ( // [RQ4]
    @(posedge clk_sys) disable iff (srst)
    !gate_closed |=> parallel_out_n_q == ~latch_q
  ) else $error("parallel outputs are not the inverted latches");

  // Closed hold keeps latches and open-gate outputs unchanged
  AST_HOLD_FREEZE: assert property ( // [RQ5]
    @(posedge clk_sys) disable iff (srst)
    (!hold_open && !gate_closed) ##1 (!hold_open && !gate_closed)
    |=> $stable(parallel_out_n_q) && $stable(latch_q)
  ) else $error("outputs changed while hold was low");

  // Open hold, open gate: every stage reaches its output
  AST_TRANSPARENT: assert property ( // [RQ1] [RQ6]
    @(posedge clk_sys) disable iff (srst)
    (hold_open && !gate_closed) |=> parallel_out_n_q == ~shift_q
  ) else $error("transparent latch did not follow register");

  // Cascade tracks stage twelve after each shift, regardless of hold
  AST_CASCADE: assert property ( // [RQ7]
    @(posedge clk_sys) disable iff (srst)
    shift_edge |=> cascade_out_q == $past(shift_q[10]) && cascade_out_q == shift_q[11]
  ) else $error("cascade output does not carry stage twelve");

  // Closed gate forces all outputs high one cycle later
  AST_GATE_FORCE: assert property ( // [RQ8]
    @(posedge clk_sys) disable iff (srst)
    gate_closed |=> parallel_out_n_q == 12'hFFF
  ) else $error("closed gate did not force outputs high");

  // Gate toggling alone leaves the register untouched
  AST_GATE_NO_SHIFT: assert property ( // [RQ9]
    @(posedge clk_sys) disable iff (srst)
    (gate_closed != $past(gate_closed)) && !shift_edge |=> $stable(shift_q)
  ) else $error("gate change disturbed the register");

  // Reset empties register and latches, closes outputs, clears cascade
  AST_OUT_RESET: assert property ( // [RQ1]
    @(posedge clk_sys)
    srst |=> shift_q == sipo_latch_pkg::SHIFT_RESET
      && latch_q == sipo_latch_pkg::LATCH_RESET
      && parallel_out_n_q == sipo_latch_pkg::OUT_RESET
      && cascade_out_q == sipo_latch_pkg::CASCADE_RESET
  ) else $error("reset did not clear register and outputs");

  // Cascade only moves on a rise, so a chained part never sees a glitch
  AST_CASCADE_STILL: assert property ( // [RQ7]
    @(posedge clk_sys) disable iff (srst)
    !shift_edge |=> $stable(cascade_out_q)
  ) else $error("cascade output changed without a serial clock rise");

  // Cascade keeps moving while the latches hold
  AST_HOLD_CASCADE: assert property ( // [RQ7]
    @(posedge clk_sys) disable iff (srst)
    !hold_open && shift_edge |=> cascade_out_q == $past(shift_q[10])
  ) else $error("cascade output stopped while hold was low");

  // Open hold: latches carry the register with no extra cycle of lag
  AST_LATCH_FOLLOW: assert property ( // [RQ6]
    @(posedge clk_sys) disable iff (srst)
    hold_open |=> latch_q == shift_q
  ) else $error("open latches did not follow the register");

  // Closed hold: latches keep their value whatever the gate does
  AST_LATCH_STILL: assert property ( // [RQ5]
    @(posedge clk_sys) disable iff (srst)
    !hold_open |=> $stable(latch_q)
  ) else $error("latches changed while hold was low");

endmodule
`default_nettype wire

// file: bench/host_model.sv
// Host controller model that shifts serial data into the latch
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  output logic serial_clk,
  output logic serial_in
);
  // Clock idles low outside frames
  initial
  begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  // One bit: setup, rise, hold, fall; each phase clears the pin filter
  task automatic send_bit(input logic b);
    @(posedge clk_sys);
    serial_in <= b;
    repeat (4) @(posedge clk_sys);
    serial_clk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Hold has run out, so the line no longer shows the bit
    serial_in <= ~b;
    serial_clk <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_sipo_latch12.sv
// Self-checking testbench for the twelve-stage serial-in latch
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_sipo_latch12;
  logic clk_sys = 1'b0; // System clock
  logic srst = 1'b1; // Reset asserted at start
  logic output_hold_n = 1'b1; // Latches open
  logic drive_gate_n = 1'b0; // Outputs driven
  logic serial_clk; // From host model
  logic serial_in; // From host model
  logic [sipo_latch_pkg::STAGE_COUNT-1:0] parallel_out_n; // Inverted latches
  logic cascade_out; // True stage twelve
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0; // Watchdog count

  // 50 ns period
  always #25 clk_sys = ~clk_sys;

  host_model host_model_inst (
    .clk_sys(clk_sys),
    .serial_clk(serial_clk),
    .serial_in(serial_in)
  );

  sipo_latch12 sipo_latch12_inst (
    .clk_sys(clk_sys),
    .srst(srst),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .output_hold_n(output_hold_n),
    .drive_gate_n(drive_gate_n),
    .parallel_out_n(parallel_out_n),
    .cascade_out(cascade_out)
  );

  // Pin filter plus output register, with margin
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask

  // Last stage's bit goes first
  task automatic send_word(input logic [11:0] w);
    for (int i = 11; i >= 0; i--)
      host_model_inst.send_bit(w[i]);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Full word with latch open and gate low
  task automatic test_load();
    send_word(12'hA5C);
    settle();
    `CHK("par", ~12'hA5C, parallel_out_n)
    `CHK("casc", 1'b1, cascade_out)
    $display("test load done");
  endtask

  // Single shifts of a one, then a zero
  task automatic test_shift();
    host_model_inst.send_bit(1'b1);
    settle();
    `CHK("par", ~12'h4B9, parallel_out_n)
    `CHK("casc", 1'b0, cascade_out)
    host_model_inst.send_bit(1'b0);
    settle();
    `CHK("par", ~12'h972, parallel_out_n)
    $display("test shift done");
  endtask

  // Shifting under hold leaves outputs frozen but moves cascade
  task automatic test_hold();
    output_hold_n <= 1'b0;
    settle();
    send_word(12'h3F0);
    settle();
    `CHK("par", ~12'h972, parallel_out_n)
    `CHK("casc", 1'b0, cascade_out)
    output_hold_n <= 1'b1;
    settle();
    `CHK("par", ~12'h3F0, parallel_out_n)
    $display("test hold done");
  endtask

  // Closed gate forces ones; shifting goes on behind it
  task automatic test_gate();
    drive_gate_n <= 1'b1;
    settle();
    `CHK("par", 12'hFFF, parallel_out_n)
    send_word(12'hC03);
    settle();
    `CHK("par", 12'hFFF, parallel_out_n)
    `CHK("casc", 1'b1, cascade_out)
    drive_gate_n <= 1'b0;
    settle();
    `CHK("par", ~12'hC03, parallel_out_n)
    $display("test gate done");
  endtask

  // Mid-run reset empties the register, then a single one shifts in
  task automatic test_reset();
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("par", sipo_latch_pkg::OUT_RESET, parallel_out_n)
    `CHK("casc", sipo_latch_pkg::CASCADE_RESET, cascade_out)
    srst <= 1'b0;
    settle();
    host_model_inst.send_bit(1'b1);
    settle();
    `CHK("par", ~12'h001, parallel_out_n)
    `CHK("casc", 1'b0, cascade_out)
    $display("test reset done");
  endtask

  // Watchdog: a hang counts as a mismatch
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    `CHK("par", 12'hFFF, parallel_out_n)
    srst <= 1'b0;
    settle();
    test_load();
    test_shift();
    test_hold();
    test_gate();
    test_reset();
    complete_run();
  end
endmodule
`default_nettype wire
